// >>> tcd_driver.sv
// driver end: serialises one frame per strobe period
`timescale 1ns/100ps
module tcd_driver
	import tcd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	tcd_link_if.driver       link,
	input  wire logic        det_clk1_in,  // detector clock sources
	input  wire logic        det_clk2_in,
	input  wire trig_frame_t frame,        // frame to send
	input  wire logic        frame_valid,
	output logic             frame_ready,  // frame taken at period start
	input  wire logic        daq_busy,     // acquisition busy, high active
	output logic             busy,         // combined busy, registered
	output logic             status
);
	logic [1:0] bsync, ssync;  // two-flop synchronisers for returned lines
	logic [$clog2(CLK_DIV)-1:0] div, next_div; // half period divider
	logic       dclk, next_dclk;    // data clock level
	logic [2:0] slot, next_slot;    // word slot within period
	logic [3:0] lanes, next_lanes;  // lane drive
	logic       stb, next_stb;      // strobe drive
	trig_frame_t cur, next_cur;     // frame being sent
	logic       take, next_take;    // pulse: frame accepted
	logic       c1, c2;             // registered detector clocks
	assign link.data_clock = dclk;
	assign link.bunch_crossing_strobe = stb;
	assign link.data_lane = lanes;
	assign link.det_clk1 = c1;
	assign link.det_clk2 = c2;
	assign frame_ready = take;
	// next state: lanes change only when data clock rises
	always_comb begin
		next_div = div;
		next_dclk = dclk;
		next_slot = slot;
		next_lanes = lanes;
		next_stb = stb;
		next_cur = cur;
		next_take = 1'b0;
		if (div == $clog2(CLK_DIV)'(CLK_DIV - 1)) begin
			next_div = '0;
			next_dclk = ~dclk;
			if (!dclk) begin // rising edge next
				next_slot = (slot == 3'(WORDS - 1)) ? 3'h0 : slot + 3'h1;
				case (next_slot)
					3'h0: begin
						// busy blocks new triggers
						// commands come only from the controller's frame, so the driver
						// never invents a clear for an event already sent
						if (frame_valid && !busy && !daq_busy) begin
							next_cur = frame;
							next_take = 1'b1;
							next_lanes = frame.trig_cmd;
						end else begin
							next_cur = '0;
							next_lanes = NULL_CMD;
						end
						next_stb = 1'b1;
					end
					3'h1: begin
						next_lanes = cur.acquisition_command_word;
						next_stb = 1'b0;
					end
					3'h2: next_lanes = cur.token[3:0];
					3'h3: next_lanes = cur.token[7:4];
					3'h4: next_lanes = cur.token[11:8];
					default: next_lanes = NULL_CMD;
				endcase
			end
		end else begin
			next_div = div + 1'b1;
		end
	end
	// registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div <= '0;
			dclk <= 1'b0;
			slot <= 3'(WORDS - 1);
			lanes <= 4'h0;
			stb <= 1'b0;
			cur <= '0;
			take <= 1'b0;
			bsync <= 2'b00;
			ssync <= 2'b00;
			busy <= 1'b0;
			status <= 1'b0;
			c1 <= 1'b0;
			c2 <= 1'b0;
		end else begin
			div <= next_div;
			dclk <= next_dclk;
			slot <= next_slot;
			lanes <= next_lanes;
			stb <= next_stb;
			cur <= next_cur;
			take <= next_take;
			bsync <= {bsync[0], link.busy_wire};
			ssync <= {ssync[0], link.status_wire};
			// combined busy: returned front-end busy or acquisition busy
			busy <= bsync[1] | daq_busy;
			status <= ssync[1];
			c1 <= det_clk1_in;
			c2 <= det_clk2_in;
		end
	end
endmodule

// >>> tcd_link_chk.sv
// link-side assertions for the trigger clock link
`timescale 1ns/100ps
module tcd_link_chk (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       data_clock,
	input wire logic       bunch_crossing_strobe,
	input wire logic [3:0] data_lane
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_lane_on_rise: assert property (
		$changed(data_lane) |-> $rose(data_clock)) else $error("lanes moved off a rise");
	a_lane_hold: assert property (
		$rose(data_clock) |-> ##1 $stable(data_lane)[*3]) else $error("lanes not held");
	a_strobe_on_rise: assert property (
		$rose(bunch_crossing_strobe) |-> $rose(data_clock)) else $error("strobe off rise");
	a_strobe_width: assert property (
		$rose(bunch_crossing_strobe) |-> bunch_crossing_strobe[*4] ##1 !bunch_crossing_strobe)
		else $error("strobe width wrong");
	a_strobe_gap: assert property (
		$fell(bunch_crossing_strobe) |-> !bunch_crossing_strobe[*8]) else $error("strobe early");
	a_frame_period: assert property (
		$rose(bunch_crossing_strobe) |-> ##20 $rose(bunch_crossing_strobe))
		else $error("strobe period wrong");
	a_dclk_period: assert property (
		$rose(data_clock) |-> ##4 $rose(data_clock)) else $error("data clock period wrong");
	a_dclk_duty: assert property (
		$rose(data_clock) |-> data_clock[*2] ##1 !data_clock[*2]) else $error("data clock duty");
endmodule

// >>> tcd_link_if.sv
// link wires between driver and receiver
`timescale 1ns/100ps
interface tcd_link_if;
	logic       data_clock;            // forwarded data clock, 5x strobe
	logic       bunch_crossing_strobe; // period marker
	logic [3:0] data_lane;             // data_lane_0..data_lane_3
	logic       det_clk1;              // detector clock 1
	logic       det_clk2;              // detector clock 2
	logic       busy_out;              // receiver drive of busy
	logic       busy_oe;               // receiver enable of busy
	logic       status_out;            // receiver drive of status
	logic       status_oe;             // receiver enable of status
	logic       busy_wire;             // resolved wired or
	logic       status_wire;           // resolved wired or
	// wired or: an undriven line reads low
	assign busy_wire   = busy_oe & busy_out;
	assign status_wire = status_oe & status_out;
	modport driver (output data_clock, bunch_crossing_strobe, data_lane, det_clk1,
		det_clk2, input busy_wire, status_wire);
	modport receiver (input data_clock, bunch_crossing_strobe, data_lane, det_clk1,
		det_clk2, output busy_out, busy_oe, status_out, status_oe);
endinterface

// >>> tcd_pkg.sv
// constants and types shared by both ends of the trigger clock link
// What this block does
// - five nibbles: command, acquisition command, token
// - data clock runs five times strobe rate
// - command word starts with strobe rising edge
// - receiver buffers remaining words of period
// - driver changes lanes on data clock rise
// - receiver samples lanes on data clock fall
// - only strobe leading edge marks timing
// - command output holds last non-zero command
// - busy and status returned as wired or
// - two detector clocks driven and forwarded
// - busy high means busy asserted
// - no triggers issued while busy asserted
// - fast detectors buffer slow-coincident event data
// - send data only after second level accept; the driver sends the acquisition word and token of every taken frame
// - no clear after event fully transmitted
package tcd_pkg;
	localparam int unsigned NIBBLE_W     = 4;  // width of one lane word
	localparam int unsigned WORDS        = 5;  // words per strobe period
	localparam int unsigned TOKEN_W      = 12; // token width
	localparam int unsigned CLK_DIV      = 2;  // driver clk cycles per data clock half
	localparam logic [3:0]  ACCEPT2_CMD  = 4'hf; // second level accept command
	localparam logic [3:0]  NULL_CMD     = 4'h0; // no command
	typedef struct packed {
		logic [3:0]  trig_cmd;
		logic [3:0]  acquisition_command_word;
		logic [11:0] token;
	} trig_frame_t;
endpackage

// >>> tcd_receiver.sv
// receiver end: deserialises frames on the link clock and hands them to clk
`timescale 1ns/100ps
module tcd_receiver
	import tcd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	tcd_link_if.receiver     link,
	output trig_frame_t      frame,       // buffered frame
	output logic             frame_valid,
	input  wire logic        frame_ready,
	output logic [3:0]       last_cmd,    // last non-zero command
	output logic             accept2,     // pulse on second level accept
	output logic             det_clk1_out,
	output logic             det_clk2_out,
	input  wire logic        fe_busy,     // front-end busy, high active
	input  wire logic        fe_status
);
	// link domain: sample on falling data clock
	logic        stb_d, next_stb_d;     // strobe sampled, for edge detect
	logic [2:0]  cnt, next_cnt;         // words captured
	logic [15:0] sh, next_sh;           // words after the command
	logic [3:0]  cmd, next_cmd;
	trig_frame_t lf, next_lf;           // completed frame
	logic        tgl, next_tgl;         // toggles when frame completes
	always_comb begin
		next_stb_d = link.bunch_crossing_strobe;
		next_cnt = cnt;
		next_sh = sh;
		next_cmd = cmd;
		next_lf = lf;
		next_tgl = tgl;
		// only the leading edge restarts; pulse width ignored
		if (link.bunch_crossing_strobe && !stb_d) begin
			next_cmd = link.data_lane;
			next_cnt = 3'h1;
		end else if (cnt != 3'h0 && cnt < 3'(WORDS)) begin
			next_sh = {link.data_lane, sh[15:4]};
			next_cnt = cnt + 3'h1;
			if (cnt == 3'(WORDS - 1)) begin // all five in
				// sh holds token bits 7..0 on top and the acquisition word below them
				next_lf = {cmd, sh[7:4], link.data_lane, sh[15:8]};
				next_tgl = ~tgl;
				next_cnt = 3'h0;
			end
		end
	end
	always_ff @(negedge link.data_clock or negedge rst_b) begin
		if (!rst_b) begin
			stb_d <= 1'b0;
			cnt <= 3'h0;
			sh <= 16'h0000;
			cmd <= 4'h0;
			lf <= '0;
			tgl <= 1'b0;
		end else begin
			stb_d <= next_stb_d;
			cnt <= next_cnt;
			sh <= next_sh;
			cmd <= next_cmd;
			lf <= next_lf;
			tgl <= next_tgl;
		end
	end
	// clk domain: toggle crossing; lf stays stable a whole period after toggle
	logic [2:0]  ts;                    // toggle sync plus edge history
	logic        ev;
	assign ev = ts[2] ^ ts[1];
	logic [1:0]  cs1, cs2;              // detector clock synchronisers
	// two-entry buffer: a frame arriving while both entries are full is lost
	trig_frame_t buf0, buf1, next_buf0, next_buf1;
	logic [1:0]  fill, next_fill;
	logic [3:0]  next_last;
	logic        next_acc;
	always_comb begin
		next_buf0 = buf0;
		next_buf1 = buf1;
		next_fill = fill;
		next_last = last_cmd;
		next_acc = 1'b0;
		if (frame_valid && frame_ready) begin // pop
			next_buf0 = buf1;
			next_fill = fill - 2'h1;
		end
		if (ev) begin
			if (lf.trig_cmd != NULL_CMD) next_last = lf.trig_cmd;
			next_acc = (lf.trig_cmd == ACCEPT2_CMD);
			// full buffer drops only when consumer stalls two periods
			if (next_fill == 2'h0) next_buf0 = lf;
			else if (next_fill == 2'h1) next_buf1 = lf;
			if (next_fill != 2'h2) next_fill = next_fill + 2'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ts <= 3'b000;
			cs1 <= 2'b00;
			cs2 <= 2'b00;
			buf0 <= '0;
			buf1 <= '0;
			fill <= 2'h0;
			last_cmd <= 4'h0;
			accept2 <= 1'b0;
			det_clk1_out <= 1'b0;
			det_clk2_out <= 1'b0;
			frame <= '0;
			frame_valid <= 1'b0;
		end else begin
			ts <= {ts[1:0], tgl};
			cs1 <= {cs1[0], link.det_clk1};
			cs2 <= {cs2[0], link.det_clk2};
			det_clk1_out <= cs1[1];
			det_clk2_out <= cs2[1];
			buf0 <= next_buf0;
			buf1 <= next_buf1;
			fill <= next_fill;
			last_cmd <= next_last;
			accept2 <= next_acc;
			frame <= next_buf0;
			frame_valid <= (next_fill != 2'h0);
		end
	end
	// feedback lines drive only when asserted, so several receivers or
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link.busy_out <= 1'b0;
			link.busy_oe <= 1'b0;
			link.status_out <= 1'b0;
			link.status_oe <= 1'b0;
		end else begin
			link.busy_out <= fe_busy;
			link.busy_oe <= fe_busy;
			link.status_out <= fe_status;
			link.status_oe <= fe_status;
		end
	end
endmodule

// >>> trigger_clock_receiver_tb.sv
// self-checking bench: driver and receiver joined across the link
`timescale 1ns/100ps
module trigger_clock_receiver_tb;
	import tcd_pkg::*;
	logic        clk = 0, rst_b = 0, c1 = 0, c2 = 0, o1, o2; // clocks, reset, detector clocks
	trig_frame_t tx_frame = '0, rx_frame;                    // user-side frames
	logic        tx_valid = 0, tx_ready, rx_valid, rx_ready = 0;
	logic        daq_busy = 0, fe_busy = 0, fe_status = 0, busy, status, accept2;
	logic [3:0]  last_cmd, w[5];                               // captured lane words
	logic [31:0] seed = 32'h14cf3;                             // xorshift state
	int          n_fail = 0, check_count = 0, n = 6, lc = 0, acc = 0, a2 = 0, np = 0;
	trig_frame_t sentq[$], rxq[$];                             // model queues
	tcd_link_if link();
	tcd_driver tcd_driver_inst (.clk(clk), .rst_b(rst_b), .link(link), .det_clk1_in(c1),
		.det_clk2_in(c2), .frame(tx_frame), .frame_valid(tx_valid), .frame_ready(tx_ready),
		.daq_busy(daq_busy), .busy(busy), .status(status));
	tcd_receiver tcd_receiver_inst (.clk(clk), .rst_b(rst_b), .link(link), .frame(rx_frame),
		.frame_valid(rx_valid), .frame_ready(rx_ready), .last_cmd(last_cmd), .accept2(accept2),
		.det_clk1_out(o1), .det_clk2_out(o2), .fe_busy(fe_busy), .fe_status(fe_status));
	tcd_link_chk chk (.clk(clk), .rst_b(rst_b), .data_clock(link.data_clock),
		.bunch_crossing_strobe(link.bunch_crossing_strobe), .data_lane(link.data_lane));
	always #20 clk = ~clk;
	function automatic logic [19:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[19:0];
	endfunction
	task automatic check(string what, logic [19:0] got, logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// receiver frames checked against link captures; busy periods take none and send zeros
	always @(posedge clk) begin
		if (accept2) a2++;
		if (rst_b && rx_valid && rx_ready) begin
			np++;
			check("rx frame", rx_frame, rxq.size() ? rxq.pop_front() : 20'hfffff);
		end
	end
	// bench capture mid-eye; the strobe marks the command word
	always @(negedge link.data_clock) begin
		if (link.bunch_crossing_strobe) n = 0;
		if (n < 5) w[n] = link.data_lane;
		n++;
		if (n == 5) begin
			rxq.push_back({w[0], w[1], w[4], w[3], w[2]});
			check("link frame", {w[0], w[1], w[4], w[3], w[2]}, sentq.size() ? sentq.pop_front() : '0);
			if (w[0] != 4'h0) lc = w[0];
			if (w[0] == ACCEPT2_CMD) acc++;
		end
	end
	// zero commands must leave the held command alone
	always @(negedge link.bunch_crossing_strobe) if (rst_b) check("last cmd", last_cmd, lc);
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_b = 1;
		tx_valid = 1;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1;
			// the taken frame is still on the inputs; record it before replacing it
			if (tx_ready) begin
				sentq.push_back(tx_frame);
				tx_frame = rnd();
			end
			// short stalls mostly, one long stall that the buffer must absorb
			rx_ready = (i < 1000 || i > 1030) && (rnd() % 4 != 0);
			fe_busy = i inside {[1500:1700]};
			fe_status = fe_busy;
			daq_busy = i inside {[2000:2200]};
			c1 = i[4];
			c2 = i[5];
			if (i % 16 == 15) check("det clock 1", o1, c1);
			if (i % 32 == 31) check("det clock 2", o2, c2);
			if (i == 1490) check("idle busy", busy, 1'b0);
			if (i == 1690) check("fe busy", {busy, status}, 2'b11);
			if (i == 2190) check("daq busy", busy, 1'b1);
		end
		tx_valid = 0;
		rx_ready = 1;
		repeat (200) @(posedge clk);
		check("accept count", a2, acc);
		check("frames left", rxq.size(), 0);
		check("frames moved", np > 50, 1'b1);
		close_out();
	end
endmodule
